// ===== rtl/rsf_pkg.sv
// Shared constants and types of the serial clock front end
package rsf_pkg;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int RSF_CLK_HZ = 100_000_000;
	localparam int RSF_XTAL_HZ = 32_768;
	// Half period of the 32.768 kHz output, rounded down
	localparam int RSF_HALF_CYC = RSF_CLK_HZ / (2 * RSF_XTAL_HZ);
	localparam logic [10:0] RSF_HALF_LAST = 11'(RSF_HALF_CYC - 1);
	// 32.768 kHz periods in one second
	localparam int RSF_SEC_TICKS = 32_768;

	////////////////////////////////////////////////////////////////////////
	// Serial framing
	localparam int RSF_BITS = 8;
	localparam logic [2:0] RSF_BIT_LAST = 3'(RSF_BITS - 1);
	localparam int RSF_PIN_CS = 0;
	localparam int RSF_PIN_SCK = 1;
	localparam int RSF_PIN_SIO = 2;
	localparam int RSF_PINS = 3;

	////////////////////////////////////////////////////////////////////////
	// Calendar limits, years 2000 to 2099 held as 0 to 99
	localparam logic [6:0] RSF_YEAR_LAST = 7'h63;
	localparam logic [3:0] RSF_MONTH_LAST = 4'hC;
	localparam logic [3:0] RSF_MONTH_FEB = 4'h2;
	localparam logic [4:0] RSF_HOUR_LAST = 5'h17;
	localparam logic [5:0] RSF_MIN_LAST = 6'h3B;
	localparam logic [5:0] RSF_SEC_LAST = 6'h3B;

	typedef struct packed {
		logic [6:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
	} rsf_time_t;

	localparam rsf_time_t RSF_TIME_RST = '{year: 7'h00, month: 4'h1,
		day: 5'h01, hour: 5'h00, minute: 6'h00, second: 6'h00};

	////////////////////////////////////////////////////////////////////////
	// Interrupt pin sources
	typedef enum logic [2:0] {
		RSF_SRC_ALARM1 = 3'b000,
		RSF_SRC_ALARM2 = 3'b001,
		RSF_SRC_USER_FREQ = 3'b010,
		RSF_SRC_MINUTE1 = 3'b011,
		RSF_SRC_MINUTE2 = 3'b100,
		RSF_SRC_CLK32K = 3'b101
	} rsf_int_src_t;

	typedef struct packed {
		logic alarm1;
		logic alarm2;
		logic user_freq;
		logic minute1;
		logic minute2;
	} rsf_irq_req_t;

	typedef enum logic [1:0] {
		RSF_ST_IDLE = 2'b00,
		RSF_ST_RX = 2'b01,
		RSF_ST_TX = 2'b10
	} rsf_ser_state_t;

endpackage

// ===== rtl/rsf_calendar.sv
// Calendar counter with leap years through 2099
`timescale 1ns/1ps
`default_nettype none
module rsf_calendar (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Control
	input wire logic sec_tick,
	input wire logic time_load,
	input wire rsf_pkg::rsf_time_t time_in,
	// Time
	output var rsf_pkg::rsf_time_t time_now
);
	import rsf_pkg::*;

	rsf_time_t next_now;

	function automatic logic [4:0] days_in(logic [3:0] m, logic [6:0] y);
		logic [4:0] d;
		d = 5'h1F;
		case (m)
			4'h4, 4'h6, 4'h9, 4'hB: d = 5'h1E;
			// Every fourth year up to 2099 is leap, 2000 included
			4'h2: d = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
			default: d = 5'h1F;
		endcase
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Carry chain
	always_comb begin
		next_now = time_now;
		if (time_now.second != RSF_SEC_LAST) begin
			next_now.second = time_now.second + 6'h01;
		end else begin
			next_now.second = 6'h00;
			if (time_now.minute != RSF_MIN_LAST) begin
				next_now.minute = time_now.minute + 6'h01;
			end else begin
				next_now.minute = 6'h00;
				if (time_now.hour != RSF_HOUR_LAST) begin
					next_now.hour = time_now.hour + 5'h01;
				end else begin
					next_now.hour = 5'h00;
					if (time_now.day != days_in(time_now.month,
						time_now.year)) begin
						next_now.day = time_now.day + 5'h01;
					end else begin
						next_now.day = 5'h01;
						if (time_now.month != RSF_MONTH_LAST) begin
							next_now.month = time_now.month + 4'h1;
						end else begin
							next_now.month = 4'h1;
							next_now.year = (time_now.year == RSF_YEAR_LAST) ?
								7'h00 : time_now.year + 7'h01;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			time_now <= RSF_TIME_RST;
		end else if (time_load) begin
			time_now <= time_in;
		end else if (sec_tick) begin
			time_now <= next_now;
		end
	end

	leap_day_a: assert property (@(posedge clock) disable iff (!rstn)
		$past(sec_tick) && !$past(time_load)
		&& $past(time_now.month) == RSF_MONTH_FEB
		&& $past(time_now.day) == 5'h1C && $past(time_now.hour) == RSF_HOUR_LAST
		&& $past(time_now.minute) == RSF_MIN_LAST
		&& $past(time_now.second) == RSF_SEC_LAST
		|-> time_now.day == (($past(time_now.year[1:0]) == 2'h0) ? 5'h1D : 5'h01))
		else $error("February end mishandled");

endmodule
`default_nettype wire

// ===== rtl/rsf_front_end.sv
// Serial front end, interrupt pin routing and calendar of the clock chip
`timescale 1ns/1ps
`default_nettype none
module rsf_front_end #(
	parameter int SEC_TICKS = 32_768
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Serial pins
	input wire logic cs_in,
	input wire logic sck_in,
	input wire logic sio_in,
	output var logic sio_out,
	output var logic sio_oe_n,
	// Interrupt pin
	output var logic int_out,
	output var logic int_oe_n,
	// Interrupt source selection and requests
	input wire rsf_pkg::rsf_int_src_t int_sel,
	input wire rsf_pkg::rsf_irq_req_t irq_req,
	// Received bytes
	output var logic [7:0] rx_byte,
	output var logic rx_valid,
	// Bytes to send
	input wire logic [7:0] tx_byte,
	input wire logic tx_load,
	output var logic tx_done,
	// Calendar
	input wire logic time_load,
	input wire rsf_pkg::rsf_time_t time_in,
	output var rsf_pkg::rsf_time_t time_now
);
	import rsf_pkg::*;

	logic [RSF_PINS-1:0] pins_raw;
	logic [RSF_PINS-1:0] pin_lvl;
	logic cs_lvl;
	logic sck_lvl;
	logic sio_lvl;
	logic cs_prev;
	logic sck_prev;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	rsf_ser_state_t state;
	logic [2:0] bit_cnt;
	logic [7:0] rx_shift;
	logic [7:0] tx_shift;
	logic [10:0] half_cnt;
	logic clk32;
	logic half_tick;
	logic [15:0] tick_cnt;
	logic sec_tick;
	logic src_active;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers, a level counts once stages two and three agree
	assign pins_raw = {sio_in, sck_in, cs_in};

	for (genvar i = 0; i < RSF_PINS; i++) begin : g_sync
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				s1 <= 1'b0;
				s2 <= 1'b0;
				s3 <= 1'b0;
				lvl <= 1'b0;
			end else begin
				s1 <= pins_raw[i];
				s2 <= s1;
				s3 <= s2;
				if (s2 == s3) begin
					lvl <= s3;
				end
			end
		end
		assign pin_lvl[i] = lvl;
	end

	assign cs_lvl = pin_lvl[RSF_PIN_CS];
	assign sck_lvl = pin_lvl[RSF_PIN_SCK];
	assign sio_lvl = pin_lvl[RSF_PIN_SIO];

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cs_prev <= 1'b0;
			sck_prev <= 1'b0;
		end else begin
			cs_prev <= cs_lvl;
			sck_prev <= sck_lvl;
		end
	end

	assign cs_rise = cs_lvl & ~cs_prev;
	// Clock edges only count while selected
	assign sck_rise = cs_lvl & sck_lvl & ~sck_prev;
	assign sck_fall = cs_lvl & ~sck_lvl & sck_prev;

	////////////////////////////////////////////////////////////////////////
	// Transfer state
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= RSF_ST_IDLE;
		end else begin
			case (state)
				RSF_ST_IDLE: begin
					if (cs_rise) begin
						state <= RSF_ST_RX;
					end
				end
				RSF_ST_RX, RSF_ST_TX: begin
					if (!cs_lvl) begin
						state <= RSF_ST_IDLE;
					end else if (tx_load) begin
						state <= RSF_ST_TX;
					end
				end
				default: begin
					state <= RSF_ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bit counter, receive on rising and send on falling clock edges
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bit_cnt <= 3'h0;
		end else if (!cs_lvl || cs_rise || tx_load) begin
			bit_cnt <= 3'h0;
		end else if (state == RSF_ST_RX && sck_rise) begin
			bit_cnt <= bit_cnt + 3'h1;
		end else if (state == RSF_ST_TX && sck_fall) begin
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rx_shift <= 8'h00;
		end else if (!cs_lvl) begin
			rx_shift <= 8'h00;
		end else if (state == RSF_ST_RX && sck_rise) begin
			rx_shift <= {rx_shift[6:0], sio_lvl};
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rx_byte <= 8'h00;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (state == RSF_ST_RX && sck_rise && bit_cnt == RSF_BIT_LAST) begin
				rx_byte <= {rx_shift[6:0], sio_lvl};
				rx_valid <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Send path, ones are shifted in so the line releases after a byte
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tx_shift <= 8'hFF;
		end else if (!cs_lvl) begin
			tx_shift <= 8'hFF;
		end else if (tx_load) begin
			tx_shift <= tx_byte;
		end else if (state == RSF_ST_TX && sck_fall) begin
			tx_shift <= {tx_shift[6:0], 1'b1};
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sio_oe_n <= 1'b1;
		end else if (!cs_lvl || state != RSF_ST_TX) begin
			sio_oe_n <= 1'b1;
		end else if (sck_fall) begin
			sio_oe_n <= tx_shift[7];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tx_done <= 1'b0;
		end else begin
			tx_done <= state == RSF_ST_TX && sck_fall && bit_cnt == RSF_BIT_LAST;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Open drain pins only ever drive low
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sio_out <= 1'b0;
			int_out <= 1'b0;
		end else begin
			sio_out <= 1'b0;
			int_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// 32.768 kHz output and second tick
	assign half_tick = half_cnt == RSF_HALF_LAST;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			half_cnt <= 11'h000;
			clk32 <= 1'b0;
		end else if (half_tick) begin
			half_cnt <= 11'h000;
			clk32 <= ~clk32;
		end else begin
			half_cnt <= half_cnt + 11'h001;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tick_cnt <= 16'h0000;
			sec_tick <= 1'b0;
		end else begin
			sec_tick <= 1'b0;
			if (half_tick && clk32) begin
				if (tick_cnt == 16'(SEC_TICKS - 1)) begin
					tick_cnt <= 16'h0000;
					sec_tick <= 1'b1;
				end else begin
					tick_cnt <= tick_cnt + 16'h0001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt pin routing
	always_comb begin
		case (int_sel)
			RSF_SRC_ALARM1: src_active = irq_req.alarm1;
			RSF_SRC_ALARM2: src_active = irq_req.alarm2;
			RSF_SRC_USER_FREQ: src_active = irq_req.user_freq;
			RSF_SRC_MINUTE1: src_active = irq_req.minute1;
			RSF_SRC_MINUTE2: src_active = irq_req.minute2;
			RSF_SRC_CLK32K: src_active = clk32;
			default: src_active = 1'b0;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			int_oe_n <= 1'b1;
		end else begin
			int_oe_n <= ~src_active;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Calendar
	rsf_calendar u_calendar (
		.clock(clock),
		.rstn(rstn),
		.sec_tick(sec_tick),
		.time_load(time_load),
		.time_in(time_in),
		.time_now(time_now)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence cs_rise_s;
		$rose(cs_lvl);
	endsequence

	sequence rx_last_s;
		state == RSF_ST_RX && sck_rise && bit_cnt == RSF_BIT_LAST;
	endsequence

	cs_idle_hiz_a: assert property (@(posedge clock) disable iff (!rstn)
		!cs_lvl |=> sio_oe_n)
		else $error("Data line driven while deselected");

	cs_rise_rx_a: assert property (@(posedge clock) disable iff (!rstn)
		cs_rise_s |=> state == RSF_ST_RX && sio_oe_n)
		else $error("Select rise did not enter receive");

	idle_no_count_a: assert property (@(posedge clock) disable iff (!rstn)
		!cs_lvl |=> bit_cnt == 3'h0 && !rx_valid && !tx_done)
		else $error("Serial state moved while deselected");

	desel_clear_a: assert property (@(posedge clock) disable iff (!rstn)
		$fell(cs_lvl) |=> bit_cnt == 3'h0 && rx_shift == 8'h00)
		else $error("Partial command kept over deselect");

	bit_on_edge_a: assert property (@(posedge clock) disable iff (!rstn)
		state == RSF_ST_RX && $past(state) == RSF_ST_RX && $past(cs_lvl)
		&& !$past(tx_load) && bit_cnt != $past(bit_cnt) |-> $past(sck_rise))
		else $error("Bit counted without a clock edge");

	rx_done_a: assert property (@(posedge clock) disable iff (!rstn)
		rx_last_s |=> rx_valid && rx_byte[0] == $past(sio_lvl))
		else $error("Received byte not delivered");

	od_drive_a: assert property (@(posedge clock) disable iff (!rstn)
		!sio_oe_n |-> $past(cs_lvl) && $past(state) == RSF_ST_TX && !sio_out)
		else $error("Data line driven outside a send");

	int_alarm_a: assert property (@(posedge clock) disable iff (!rstn)
		$past(int_sel) == RSF_SRC_ALARM1 |-> int_oe_n == !$past(irq_req.alarm1))
		else $error("Alarm one not routed to the interrupt pin");

	int_clk_a: assert property (@(posedge clock) disable iff (!rstn)
		$past(int_sel) == RSF_SRC_CLK32K |-> int_oe_n == !$past(clk32) && !int_out)
		else $error("Clock output not routed to the interrupt pin");

endmodule
`default_nettype wire

// ===== verif/rsf_host_model.sv
// Host model driving chip select, serial clock and its side of the data wire
`timescale 1ns/1ps
`default_nettype none
module rsf_host_model (
	// Pins toward the device
	output var logic cs,
	output var logic sck,
	output var logic sio_oe_n,
	// Resolved data wire
	input wire logic sio_line
);
	initial begin
		cs = 1'b0;
		sck = 1'b1;
		sio_oe_n = 1'b1;
	end
	// Open select driven low, as the pull-down would leave it
	task automatic select(input logic on);
		cs = on;
		#200;
	endtask
	// Data changes with the falling half, read late in the high half
	task automatic bit_cycle(input logic b, output logic s);
		sck = 1'b0;
		sio_oe_n = b;
		#40;
		sck = 1'b1;
		#40;
		s = sio_line;
	endtask
	task automatic xfer(input logic [7:0] out, output logic [7:0] in);
		for (int i = 7; i >= 0; i--) begin
			bit_cycle(out[i], in[i]);
		end
		sio_oe_n = 1'b1;
	endtask
	task automatic pulses(input int n, input logic b);
		logic s;
		repeat (n) begin
			bit_cycle(b, s);
		end
		sio_oe_n = 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== verif/rsf_front_end_tb.sv
// Self-checking bench of the serial clock front end
`timescale 1ns/1ps
`default_nettype none
module rsf_front_end_tb;
	import rsf_pkg::*;
	localparam int SEC_TICKS = 2;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	rsf_int_src_t int_sel;
	rsf_irq_req_t irq_req;
	logic [7:0] tx_byte;
	logic tx_load;
	logic time_load;
	rsf_time_t time_in;
	logic drive_bad = 1'b0;
	logic cs_in, sck_in, h_oe_n, sio_line, sio_out, sio_oe_n;
	logic int_out, int_oe_n, int_line, rx_valid, tx_done;
	logic [7:0] rx_byte, got, cmd, val;
	logic [7:0] sent[4];
	logic [7:0] rxq[$];
	rsf_time_t time_now, t, e;
	logic [15:0] rnd = 16'h9652;
	logic [6:0] yr[5] = '{7'h04, 7'h04, 7'h03, 7'h63, 7'h00};
	logic [3:0] mo[5] = '{4'h2, 4'h2, 4'h2, 4'hC, 4'h4};
	logic [4:0] dy[5] = '{5'h1C, 5'h1D, 5'h1C, 5'h1F, 5'h1E};
	logic [3:0] nmo[5] = '{4'h2, 4'h3, 4'h3, 4'h1, 4'h5};
	logic [4:0] ndy[5] = '{5'h1D, 5'h01, 5'h01, 5'h01, 5'h01};
	int num_errors = 0;
	int checks_done = 0;
	int done_cnt = 0;
	int n;

	// Both wires pulled up, pulled low by any enabled driver
	assign sio_line = h_oe_n & sio_oe_n;
	assign int_line = int_oe_n;

	rsf_host_model host (.cs(cs_in), .sck(sck_in), .sio_oe_n(h_oe_n),
		.sio_line(sio_line));
	rsf_front_end #(.SEC_TICKS(SEC_TICKS)) dut (.clock(clock), .rstn(rstn),
		.cs_in(cs_in), .sck_in(sck_in), .sio_in(sio_line),
		.sio_out(sio_out), .sio_oe_n(sio_oe_n), .int_out(int_out),
		.int_oe_n(int_oe_n), .int_sel(int_sel), .irq_req(irq_req),
		.rx_byte(rx_byte), .rx_valid(rx_valid), .tx_byte(tx_byte),
		.tx_load(tx_load), .tx_done(tx_done), .time_load(time_load),
		.time_in(time_in), .time_now(time_now));

	initial begin
		forever #5 clock = ~clock;
	end

	always @(posedge clock) begin
		if (rx_valid === 1'b1) rxq.push_back(rx_byte);
		if (tx_done === 1'b1) done_cnt++;
		if (rstn && (sio_out !== 1'b0 || int_out !== 1'b0)) drive_bad = 1'b1;
	end

	////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic wait_expired;
		check(64'h0, 64'h1);
		tally_and_finish();
	endtask
	task automatic wait_rx(input int k);
		int w;
		w = 0;
		while (rxq.size() < k && w < 50) begin
			@(negedge clock);
			w++;
		end
		if (rxq.size() < k) wait_expired();
	endtask
	// Cycles until the interrupt wire next changes
	task automatic half_len(output int c);
		logic p;
		p = int_line;
		c = 0;
		while (int_line === p && c < 4000) begin
			@(posedge clock);
			#1;
			c++;
		end
		if (c == 4000) wait_expired();
	endtask

	////////////////////////////////////////
	initial begin
		int_sel = RSF_SRC_ALARM1;
		irq_req = '0;
		tx_byte = 8'h00;
		tx_load = 1'b0;
		time_load = 1'b0;
		time_in = RSF_TIME_RST;
		repeat (3) @(posedge clock);
		check(sio_oe_n, 1'b1);
		check(int_line, 1'b1);
		check(time_now, RSF_TIME_RST);
		@(negedge clock);
		rstn = 1'b1;
		repeat (10) @(negedge clock);
		// Deselected: send request and clock pulses both ignored
		tx_load = 1'b1;
		@(negedge clock);
		tx_load = 1'b0;
		host.pulses(8, 1'b0);
		repeat (10) @(negedge clock);
		check(rxq.size(), 0);
		check(sio_oe_n, 1'b1);
		check(done_cnt, 0);
		host.select(1'b1);
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			sent[i] = rnd[7:0];
			host.xfer(sent[i], got);
		end
		wait_rx(4);
		for (int i = 0; i < 4; i++) begin
			check(rxq[i], sent[i]);
		end
		// Part byte cut short by deselect
		host.pulses(4, 1'b0);
		host.select(1'b0);
		host.select(1'b1);
		rnd = lfsr(rnd);
		host.xfer(rnd[7:0], got);
		wait_rx(5);
		repeat (5) @(negedge clock);
		check(rxq.size(), 5);
		check(rxq[4], rnd[7:0]);
		host.select(1'b0);
		// Command in, reply out, one per select period
		for (int k = 0; k < 3; k++) begin
			host.select(1'b1);
			rnd = lfsr(rnd);
			cmd = rnd[7:0];
			host.xfer(cmd, got);
			wait_rx(6 + k);
			check(rxq[5 + k], cmd);
			rnd = lfsr(rnd);
			val = (k == 0) ? rnd[7:0] : (k == 1) ? 8'h00 : 8'h01;
			@(negedge clock);
			tx_byte = val;
			tx_load = 1'b1;
			@(negedge clock);
			tx_load = 1'b0;
			host.xfer(8'hFF, got);
			check(got, val);
			repeat (3) @(negedge clock);
			check(done_cnt, k + 1);
			host.select(1'b0);
			check(sio_oe_n, 1'b1);
		end
		// Interrupt source routing, codes 6 and 7 leave the pin released
		for (int s = 0; s < 8; s++) begin
			for (int j = 0; j < 2 && s != 5; j++) begin
				rnd = lfsr(rnd);
				@(negedge clock);
				int_sel = rsf_int_src_t'(s[2:0]);
				irq_req = rsf_irq_req_t'(rnd[4:0]);
				repeat (3) @(negedge clock);
				check(int_line, s < 5 ? !rnd[4 - s] : 1'b1);
			end
		end
		int_sel = RSF_SRC_CLK32K;
		// Let the switch of source settle before timing halves
		repeat (3) @(negedge clock);
		half_len(n);
		half_len(n);
		check(n, RSF_HALF_CYC);
		half_len(n);
		check(n, RSF_HALF_CYC);
		// Calendar carries at month and year ends and into the leap day
		for (int c = 0; c < 5; c++) begin
			rnd = lfsr(rnd);
			t = '{year: yr[c], month: mo[c], day: dy[c], hour: 5'h17,
				minute: 6'h3B, second: 6'h3B};
			if (c == 4) t.year = rnd[6:0] % 7'h64;
			e = '{year: (c == 3) ? 7'h00 : t.year, month: nmo[c],
				day: ndy[c], hour: 5'h00, minute: 6'h00, second: 6'h00};
			@(negedge clock);
			time_in = t;
			time_load = 1'b1;
			@(negedge clock);
			time_load = 1'b0;
			check(time_now, t);
			n = 0;
			while (time_now === t && n < 7000) begin
				@(negedge clock);
				n++;
			end
			if (n == 7000) wait_expired();
			check(time_now, e);
		end
		check(drive_bad, 1'b0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
